// [rtl/poc_pkg.sv]
// Constants and types for the pulse output and PLL pin override control.
// Assumes one 100 MHz clock and a register port fed by the serial interface.
package poc_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_PULSE = 8'h57;
	localparam logic [7:0] ADDR_OVR = 8'h58;
	localparam logic [7:0] ADDR_TRIM = 8'h59;
	localparam logic [7:0] RST_PULSE = 8'h00;
	localparam logic [7:0] RST_OVR = 8'h00;
	localparam logic [7:0] RST_TRIM = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ==========================================================
	// Field positions
	localparam int PULSE_EN_BIT = 7;
	localparam int MODE_MSB = 2;
	localparam int OVR_EN_BIT = 7;
	localparam int SECOND_LSB = 4;
	localparam int FIRST_LSB = 2;
	localparam int SE_BIT = 1;
	localparam int PLL_EN_BIT = 0;
	localparam int TRIM_MSB = 6;

	// ==========================================================
	// Pulse output source codes and divider terminal counts
	localparam logic [2:0] MODE_UI16 = 3'h0;
	localparam logic [2:0] MODE_UI32 = 3'h1;
	localparam logic [2:0] MODE_UI64 = 3'h2;
	localparam logic [2:0] MODE_STAMP = 3'h3;
	localparam logic [1:0] TC_UI16 = 2'h0;
	localparam logic [1:0] TC_UI32 = 2'h1;
	localparam logic [1:0] TC_UI64 = 2'h3;
	localparam logic [1:0] REF_OFF = 2'h0;
	localparam logic [1:0] REF_DIV1 = 2'h1;
	localparam logic [1:0] REF_DIV2 = 2'h2;

	// Pulse output sequencer states.
	typedef enum logic [4:0] {
		ST_OFF = 5'h01,
		ST_CLKDIV = 5'h02,
		ST_STAMP = 5'h04,
		ST_IDLE = 5'h08,
		ST_REINIT = 5'h10
	} poc_state_type;

	// Settings delivered to the PLL and its divided-reference outputs.
	typedef struct packed {
		logic enable;
		logic single_ended;
		logic [1:0] first_ref_out_mode;
		logic [1:0] second_ref_out_mode;
	} poc_pll_cfg_type;

endpackage : poc_pkg

// [rtl/poc_ctrl.sv]
// Pulse output source selection and PLL pin override control.
// Assumes register accesses arrive on ref_clk; pins and timestamp are asynchronous.
//
// Overview of operation
// - Enable bit 7 clear keeps pulse buffer and divider off; set enables.
// - Mode 0,1,2 give 16, 32, 64 UI clocks; 3 timestamp; 4-7 reserved.
// - Modes 0 to 2 follow serializer clocking, broken during serializer reinit.
// - Pulse output control register resets to zero: disabled, mode 0.
// - Override bit 7 clear follows pins; set uses register override values.
// - Override register resets to zero: pin control, overrides inactive.
// - Under override, bits 5:4 set second output: off, divide 1, 2, 4.
// - Without override, the clock config pins set the second output.
// - Second output clocks only while first output also clocks.
// - Under override, bits 3:2 set first output: off, divide 1, 2, 4.
// - Without override, the clock config pins set the first output.
// - Under override, bit 1 selects single-ended reference instead of pin.
// - Under override, bit 0 enables the PLL instead of enable pin.
// - Oscillator trim register lives at 0x59.
// - Trim holds seven bits, set by calibration, readable and reloadable.
module poc_ctrl
	import poc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic pll_en_pin,
	input wire logic ref_single_ended_pin,
	input wire logic clock_cfg_pin0,
	input wire logic clock_cfg_pin1,
	input wire logic timestamp_in,
	input wire logic ser_half_tick,
	input wire logic ser_reinit,
	input wire logic cal_trim_wr,
	input wire logic [6:0] cal_trim_value,
	output logic pulse_out,
	output logic pulse_out_buf_en,
	output poc_pll_cfg_type pll_cfg,
	output logic [6:0] osc_freq_trim
);

	// ==========================================================
	// Reset release
	// Release is synchronised so no flop leaves reset on a split edge.
	logic rst_s1_r;
	logic rst_s2_r;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'h0;
			rst_s2_r <= 1'h0;
		end else begin
			rst_s1_r <= 1'h1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire rst_n = rst_s2_r;

	// ==========================================================
	// Pin synchronisers
	// Stage one is read only by stage two to keep metastability contained.
	logic [4:0] pin_s1_r;
	logic [4:0] pin_s2_r;
	wire [4:0] pin_raw = {timestamp_in, clock_cfg_pin1, clock_cfg_pin0,
		ref_single_ended_pin, pll_en_pin};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end
	wire ts_s = pin_s2_r[4];

	// ==========================================================
	// Helper functions
	// Terminal count of the half-period tick divider for a clock mode.
	function automatic logic [1:0] div_tc(input logic [2:0] mode);
		case (mode)
			MODE_UI32: div_tc = TC_UI32;
			MODE_UI64: div_tc = TC_UI64;
			default: div_tc = TC_UI16;
		endcase
	endfunction : div_tc

	// The second reference output may only run when the first one runs.
	function automatic logic [1:0] gate_second(input logic [1:0] first,
		input logic [1:0] second);
		gate_second = (first == REF_OFF) ? REF_OFF : second;
	endfunction : gate_second

	// Pin strap decode of both divided-reference outputs.
	function automatic logic [3:0] pin_ref_decode(input logic [1:0] cfg);
		case (cfg)
			2'h1: pin_ref_decode = {REF_OFF, REF_DIV1};
			2'h2: pin_ref_decode = {REF_DIV1, REF_DIV1};
			2'h3: pin_ref_decode = {REF_DIV2, REF_DIV2};
			default: pin_ref_decode = {REF_OFF, REF_OFF};
		endcase
	endfunction : pin_ref_decode

	// ==========================================================
	// Register port decode
	logic [7:0] pulse_ctrl_r;
	logic [7:0] ovr_r;
	logic [7:0] trim_r;
	logic [7:0] rdata_r;
	wire wr_pulse = reg_wr && (reg_addr == ADDR_PULSE);
	wire wr_ovr = reg_wr && (reg_addr == ADDR_OVR);
	wire wr_trim = reg_wr && (reg_addr == ADDR_TRIM);
	wire [7:0] rd_mux = (reg_addr == ADDR_PULSE) ? pulse_ctrl_r :
		(reg_addr == ADDR_OVR) ? ovr_r :
		(reg_addr == ADDR_TRIM) ? trim_r : RD_UNMAPPED;

	// Reserved bits are stored as written; the host keeps them at zero.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_ctrl_r <= RST_PULSE;
			ovr_r <= RST_OVR;
		end else begin
			if (wr_pulse)
				pulse_ctrl_r <= reg_wdata;
			if (wr_ovr)
				ovr_r <= reg_wdata;
		end
	end

	// Calibration update wins over a colliding software write.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			trim_r <= RST_TRIM;
		else if (cal_trim_wr)
			trim_r <= {trim_r[7], cal_trim_value};
		else if (wr_trim)
			trim_r <= reg_wdata;
	end

	// Read data is held until the next read.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_r <= RD_UNMAPPED;
		else if (reg_rd)
			rdata_r <= rd_mux;
	end

	// ==========================================================
	// Pulse output sequencer
	poc_state_type state_r;
	poc_state_type state_nxt;
	logic [2:0] act_mode_r;
	wire pulse_en = pulse_ctrl_r[PULSE_EN_BIT];
	wire [2:0] reg_mode = pulse_ctrl_r[MODE_MSB:0];
	wire mode_is_clk = (reg_mode <= MODE_UI64);

	// Leaving OFF picks the source; any state returns to OFF when disabled.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: begin
				if (pulse_en) begin
					if (mode_is_clk)
						state_nxt = ST_CLKDIV;
					else if (reg_mode == MODE_STAMP)
						state_nxt = ST_STAMP;
					else
						state_nxt = ST_IDLE;
				end
			end
			ST_CLKDIV: begin
				if (!pulse_en)
					state_nxt = ST_OFF;
				else if (ser_reinit)
					state_nxt = ST_REINIT;
			end
			ST_REINIT: begin
				if (!pulse_en)
					state_nxt = ST_OFF;
				else if (!ser_reinit)
					state_nxt = ST_CLKDIV;
			end
			ST_STAMP, ST_IDLE: begin
				if (!pulse_en)
					state_nxt = ST_OFF;
			end
			default: state_nxt = ST_OFF;
		endcase
	end

	// The mode is captured only at enable, so a stray change while running
	// cannot glitch the divider.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_OFF;
			act_mode_r <= MODE_UI16;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_OFF)
				act_mode_r <= reg_mode;
		end
	end

	// ==========================================================
	// Serializer clock divider
	// One tick marks half a 16 UI period; the counter stretches it to 32 or 64.
	logic [1:0] cnt_r;
	logic phase_r;
	wire div_run = (state_r == ST_CLKDIV);
	wire div_wrap = ser_half_tick && (cnt_r == div_tc(act_mode_r));
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			phase_r <= 1'h0;
		end else if (!div_run) begin
			cnt_r <= 2'h0;
			phase_r <= 1'h0;
		end else if (div_wrap) begin
			cnt_r <= 2'h0;
			phase_r <= !phase_r;
		end else if (ser_half_tick) begin
			cnt_r <= cnt_r + 2'h1;
		end
	end

	// Pulse output and buffer enable come straight from flops.
	logic pulse_r;
	logic buf_en_r;
	wire pulse_nxt = div_run ? phase_r :
		(state_r == ST_STAMP) ? ts_s : 1'h0;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_r <= 1'h0;
			buf_en_r <= 1'h0;
		end else begin
			pulse_r <= pulse_nxt;
			buf_en_r <= pulse_en;
		end
	end

	// ==========================================================
	// PLL override selection
	wire ovr_en = ovr_r[OVR_EN_BIT];
	wire [3:0] pin_ref = pin_ref_decode(pin_s2_r[3:2]);
	wire [1:0] first_sel = ovr_en ? ovr_r[FIRST_LSB+1:FIRST_LSB] :
		pin_ref[1:0];
	wire [1:0] second_raw = ovr_en ? ovr_r[SECOND_LSB+1:SECOND_LSB] :
		pin_ref[3:2];
	poc_pll_cfg_type pll_nxt;
	poc_pll_cfg_type pll_r;
	assign pll_nxt.enable = ovr_en ? ovr_r[PLL_EN_BIT] : pin_s2_r[0];
	assign pll_nxt.single_ended = ovr_en ? ovr_r[SE_BIT] : pin_s2_r[1];
	assign pll_nxt.first_ref_out_mode = first_sel;
	assign pll_nxt.second_ref_out_mode = gate_second(first_sel, second_raw);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pll_r <= '0;
		else
			pll_r <= pll_nxt;
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = rdata_r;
	assign pulse_out = pulse_r;
	assign pulse_out_buf_en = buf_en_r;
	assign pll_cfg = pll_r;
	assign osc_freq_trim = trim_r[TRIM_MSB:0];

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	buf_follows_en_a: assert property (
		$changed(pulse_en) |=> (buf_en_r == $past(pulse_en)))
		else $error("Buffer enable did not follow enable bit.");
	off_when_disabled_a: assert property (
		!pulse_en [*2] |=> !pulse_out)
		else $error("Pulse output active while disabled.");
	reserved_idle_a: assert property (
		(state_r == ST_IDLE) |=> !pulse_out)
		else $error("Reserved mode produced output.");
	reinit_hold_a: assert property (
		(state_r == ST_CLKDIV) && ser_reinit && pulse_en |=>
		(state_r == ST_REINIT) ##1 !phase_r)
		else $error("Divider kept running in reinit.");
	mode_latched_a: assert property (
		(state_r != ST_OFF) && $stable(state_r) |-> $stable(act_mode_r))
		else $error("Active mode changed while enabled.");
	second_gated_a: assert property (
		(pll_cfg.first_ref_out_mode == REF_OFF) |->
		(pll_cfg.second_ref_out_mode == REF_OFF))
		else $error("Second output runs without first.");
	ovr_enable_a: assert property (
		ovr_en |=> (pll_cfg.enable == $past(ovr_r[PLL_EN_BIT])))
		else $error("PLL enable ignores override value.");
	pin_mode_a: assert property (
		!ovr_en ##1 !ovr_en |-> (pll_cfg.single_ended == $past(pin_s2_r[1])))
		else $error("Single-ended select ignores pin.");
	cal_priority_a: assert property (
		cal_trim_wr |=> (osc_freq_trim == $past(cal_trim_value)))
		else $error("Calibration trim update lost.");
	ui16_period_a: assert property (
		div_run && div_wrap && (act_mode_r == MODE_UI16) && !$past(div_wrap) |=>
		(phase_r != $past(phase_r)))
		else $error("16 UI divider missed a toggle.");

	stamp_cov_c: cover property (state_r == ST_STAMP ##1 pulse_out);
	ui64_cov_c: cover property (div_wrap && (act_mode_r == MODE_UI64));
	reinit_cov_c: cover property (state_r == ST_REINIT ##1 state_r == ST_CLKDIV);
	ovr_cov_c: cover property (ovr_en && pll_cfg.second_ref_out_mode != REF_OFF);

endmodule : poc_ctrl

// [test/poc_ctrl_bench.sv]
// Self-checking bench for the pulse output and PLL pin override control.
// Assumes poc_pkg is compiled first; the bench drives every input port of poc_ctrl itself.
module poc_ctrl_bench;
	import poc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// Stimulus and observed signals
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pll_en_pin = 1'b0, ref_se_pin = 1'b0;
	logic cfg0 = 1'b0, cfg1 = 1'b0, timestamp_in = 1'b0, half_tick = 1'b0, reinit = 1'b0;
	logic cal_wr = 1'b0;
	logic [6:0] cal_val = 7'h00;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic pulse_out, buf_en, po_q = 1'b0;
	poc_pll_cfg_type pll_cfg;
	logic [6:0] trim;
	int n_fail = 0, checked = 0, n_rise = 0, r0;

	// Half period of 5 ns gives the 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	poc_ctrl i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .pll_en_pin(pll_en_pin),
		.ref_single_ended_pin(ref_se_pin), .clock_cfg_pin0(cfg0), .clock_cfg_pin1(cfg1),
		.timestamp_in(timestamp_in), .ser_half_tick(half_tick), .ser_reinit(reinit),
		.cal_trim_wr(cal_wr), .cal_trim_value(cal_val), .pulse_out(pulse_out),
		.pulse_out_buf_en(buf_en), .pll_cfg(pll_cfg), .osc_freq_trim(trim));

	// Rising edges of the pulse output are counted so divide ratios can be compared.
	always @(posedge ref_clk) begin
		if (pulse_out === 1'b1 && po_q === 1'b0) n_rise++;
		po_q = pulse_out;
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// The strobe drops at the edge that takes it, so a next call never lands in the same step.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		#1 v = rdata;
	endtask : rd

	task automatic wait_clk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_clk

	// Serializer half-period ticks, spaced four cycles apart.
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			half_tick <= 1'b1;
			@(posedge ref_clk);
			half_tick <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
		wait_clk(4);
	endtask : ticks

	task automatic end_of_test;
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test

	// The whole run needs about six hundred cycles; this limit leaves ample margin.
	initial begin
		#100us;
		n_fail++;
		end_of_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		wait_clk(4);
		rd(ADDR_PULSE, d); check(d, 8'h00);
		rd(ADDR_OVR, d); check(d, 8'h00);
		check({7'h00, buf_en}, 8'h00);
		check({2'h0, pll_cfg}, 8'h00);
		$display("test reset done");
		// Divided clock modes; mode 0 also gets a mode write while enabled, which must not take.
		for (int m = 0; m < 3; m++) begin
			wr(ADDR_PULSE, 8'(m));
			wr(ADDR_PULSE, 8'h80 | 8'(m));
			wait_clk(2);
			check({7'h00, buf_en}, 8'h01);
			if (m == 0) wr(ADDR_PULSE, 8'h82);
			r0 = n_rise;
			ticks(16);
			check(8'(n_rise - r0), 8'h08 >> m);
			wr(ADDR_PULSE, 8'(m));
			wait_clk(3);
			check({6'h00, buf_en, pulse_out}, 8'h00);
		end
		$display("test divider done");
		// Serializer reinit holds the divided clock off.
		wr(ADDR_PULSE, 8'h80);
		reinit <= 1'b1;
		r0 = n_rise;
		ticks(8);
		check(8'(n_rise - r0), 8'h00);
		@(posedge ref_clk) reinit <= 1'b0;
		wr(ADDR_PULSE, 8'h00);
		// Timestamp mode follows the input level.
		wr(ADDR_PULSE, 8'h03);
		wr(ADDR_PULSE, 8'h83);
		timestamp_in <= 1'b1;
		wait_clk(6);
		check({7'h00, pulse_out}, 8'h01);
		@(posedge ref_clk) timestamp_in <= 1'b0;
		wait_clk(6);
		check({7'h00, pulse_out}, 8'h00);
		wr(ADDR_PULSE, 8'h03);
		// Reserved modes keep the output idle while ticks arrive.
		for (int m = 4; m < 8; m++) begin
			wr(ADDR_PULSE, 8'(m));
			wr(ADDR_PULSE, 8'h80 | 8'(m));
			timestamp_in <= 1'b1;
			r0 = n_rise;
			ticks(8);
			check({7'h00, pulse_out}, 8'h00);
			check(8'(n_rise - r0), 8'h00);
			@(posedge ref_clk) timestamp_in <= 1'b0;
			wr(ADDR_PULSE, 8'(m));
		end
		$display("test pulse modes done");
		// Pins set to all ones so that register values are seen to win under override.
		pll_en_pin <= 1'b1;
		ref_se_pin <= 1'b1;
		cfg0 <= 1'b1;
		cfg1 <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			for (int s = 0; s < 4; s++) begin
				wr(ADDR_OVR, 8'h80 | 8'(s << 4) | 8'(f << 2) | 8'(f & 1) << 1 | 8'(s & 1));
				wait_clk(3);
				d = {2'h0, 1'(s), 1'(f), 2'(f), (f == 0) ? 2'h0 : 2'(s)};
				check({2'h0, pll_cfg}, d);
			end
		end
		wr(ADDR_OVR, 8'h3F);
		wait_clk(8);
		check({2'h0, pll_cfg}, 8'h3A);
		@(posedge ref_clk) pll_en_pin <= 1'b0;
		ref_se_pin <= 1'b0;
		cfg1 <= 1'b0;
		wait_clk(8);
		check({2'h0, pll_cfg}, 8'h04);
		rd(ADDR_OVR, d); check(d, 8'h3F);
		$display("test override done");
		// Trim register: software access, calibration load, and calibration winning a tie.
		wr(ADDR_TRIM, 8'hFF);
		rd(ADDR_TRIM, d); check(d, 8'hFF);
		check({1'b0, trim}, 8'h7F);
		@(posedge ref_clk);
		cal_wr <= 1'b1;
		cal_val <= 7'h15;
		@(posedge ref_clk);
		cal_wr <= 1'b0;
		wait_clk(2);
		check({1'b0, trim}, 8'h15);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		addr <= ADDR_TRIM;
		wdata <= 8'h22;
		cal_wr <= 1'b1;
		cal_val <= 7'h33;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		cal_wr <= 1'b0;
		wait_clk(2);
		check({1'b0, trim}, 8'h33);
		wr(8'h5A, 8'h55);
		rd(8'h5A, d); check(d, RD_UNMAPPED);
		rd(ADDR_PULSE, d); check(d, 8'h07);
		$display("test trim done");
		end_of_test();
	end

endmodule : poc_ctrl_bench
